// *** sdir_pkg.sv ***
// Package: register map, field layout and step operation codes
package sdir_pkg;
   localparam int unsigned ADDR_W = 14;
   localparam logic [13:0] OFF_DEPTH_ACC   = 14'h1cc0;
   localparam logic [13:0] OFF_DEPTH_X     = 14'h1cc8;
   localparam logic [13:0] OFF_DEPTH_Y     = 14'h1ccc;
   localparam logic [13:0] OFF_RED_ACC     = 14'h1cd0;
   localparam logic [13:0] OFF_RED_X       = 14'h1cd8;
   localparam logic [13:0] OFF_RED_Y       = 14'h1cdc;
   localparam logic [13:0] OFF_GREEN_ACC   = 14'h1ce0;
   localparam logic [13:0] OFF_GREEN_X     = 14'h1ce8;
   localparam logic [13:0] OFF_GREEN_Y     = 14'h1cec;
   localparam logic [13:0] OFF_BLUE_ACC    = 14'h1cf0;
   localparam logic [13:0] OFF_BLUE_X      = 14'h1cf8;
   localparam logic [13:0] OFF_BLUE_Y      = 14'h1cfc;
   localparam logic [13:0] OFF_WIDE_Y_LOW  = 14'h2c68;
   localparam logic [13:0] OFF_WIDE_Y_HIGH = 14'h2c6c;
   localparam int unsigned WIDE_W   = 48;
   localparam int unsigned COLOR_W  = 24;
   localparam int unsigned HIGH_W   = 16;
   localparam logic [47:0] WIDE_RST  = 48'h0000_0000_0000;
   localparam logic [31:0] WORD_RST  = 32'h0000_0000;
   localparam logic [23:0] COLOR_RST = 24'h00_0000;
   typedef enum logic [1:0] {
      SDIR_STEP_NONE,
      SDIR_STEP_X,
      SDIR_STEP_Y
   } sdir_step_t;
endpackage

// *** sdir_load_if.sv ***
// Interface: decoded register write strobes from decoder to datapath
`timescale 1ns/100ps
`default_nettype none
interface sdir_load_if;
   logic [31:0] data;
   logic        wr_depth_acc;
   logic        wr_depth_x;
   logic        wr_depth_y;
   logic        wr_wide_lo;
   logic        wr_wide_hi;
   logic [3:0]  wr_acc;
   logic [3:0]  wr_x;
   logic [3:0]  wr_y;
   modport dec (output data, wr_depth_acc, wr_depth_x, wr_depth_y, wr_wide_lo,
                wr_wide_hi, wr_acc, wr_x, wr_y);
   modport dp  (input data, wr_depth_acc, wr_depth_x, wr_depth_y, wr_wide_lo,
                wr_wide_hi, wr_acc, wr_x, wr_y);
endinterface
`default_nettype wire

// *** sdir_decode.sv ***
// Address decoder turning one accepted register write into strobes
`timescale 1ns/100ps
`default_nettype none
module sdir_decode (
   input  wire logic        wr_en,
   input  wire logic [13:0] wr_addr,
   input  wire logic [31:0] wr_data,
   sdir_load_if.dec         ld
);
   function automatic logic hit(input logic [13:0] a, input logic [13:0] o);
      hit = (a == o);
   endfunction

   assign ld.data         = wr_data;
   assign ld.wr_depth_acc = wr_en & hit(wr_addr, sdir_pkg::OFF_DEPTH_ACC);
   assign ld.wr_depth_x   = wr_en & hit(wr_addr, sdir_pkg::OFF_DEPTH_X);
   assign ld.wr_depth_y   = wr_en & hit(wr_addr, sdir_pkg::OFF_DEPTH_Y);
   assign ld.wr_wide_lo   = wr_en & hit(wr_addr, sdir_pkg::OFF_WIDE_Y_LOW);
   assign ld.wr_wide_hi   = wr_en & hit(wr_addr, sdir_pkg::OFF_WIDE_Y_HIGH);
   // Index 0 red, 1 green, 2 blue
   assign ld.wr_acc = {1'b0,
                       wr_en & hit(wr_addr, sdir_pkg::OFF_BLUE_ACC),
                       wr_en & hit(wr_addr, sdir_pkg::OFF_GREEN_ACC),
                       wr_en & hit(wr_addr, sdir_pkg::OFF_RED_ACC)};
   assign ld.wr_x   = {1'b0,
                       wr_en & hit(wr_addr, sdir_pkg::OFF_BLUE_X),
                       wr_en & hit(wr_addr, sdir_pkg::OFF_GREEN_X),
                       wr_en & hit(wr_addr, sdir_pkg::OFF_RED_X)};
   assign ld.wr_y   = {1'b0,
                       wr_en & hit(wr_addr, sdir_pkg::OFF_BLUE_Y),
                       wr_en & hit(wr_addr, sdir_pkg::OFF_GREEN_Y),
                       wr_en & hit(wr_addr, sdir_pkg::OFF_RED_Y)};
endmodule
`default_nettype wire

// *** sdir_color_chan.sv ***
// One colour channel: 9.15 accumulator with x and y increments
`timescale 1ns/100ps
`default_nettype none
module sdir_color_chan #(
   parameter int unsigned W = 24
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 wr_acc,
   input  wire logic                 wr_x,
   input  wire logic                 wr_y,
   input  wire logic [31:0]          data,
   input  wire sdir_pkg::sdir_step_t step,
   output logic      [W-1:0]         acc,
   output logic      [W-1:0]         x_inc,
   output logic      [W-1:0]         y_inc
);
   logic [W-1:0] acc_q;
   logic [W-1:0] acc_d;
   logic [W-1:0] x_q;
   logic [W-1:0] y_q;
   logic [W-1:0] sel_inc;

   assign sel_inc = (step == sdir_pkg::SDIR_STEP_X) ? x_q : y_q;
   // Bits above W dropped; software keeps them zero
   assign acc_d = wr_acc ? data[W-1:0]
                : (step != sdir_pkg::SDIR_STEP_NONE) ? W'(acc_q + sel_inc)
                : acc_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         acc_q <= '0;
         x_q   <= '0;
         y_q   <= '0;
      end else begin
         acc_q <= acc_d;
         if (wr_x) begin
            x_q <= data[W-1:0];
         end
         if (wr_y) begin
            y_q <= data[W-1:0];
         end
      end
   end

   assign acc   = acc_q;
   assign x_inc = x_q;
   assign y_inc = y_q;
endmodule
`default_nettype wire

// *** sdir_regs.sv ***
// Top: interpolation register bank with depth aliasing and stepping
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Wide depth y-step is 48 bits: low word full, high word bits 15..0.
// - Fills use wide y-step as depth y increment, signed 33.15.
// - Strokes use wide y-step as depth diagonal increment, signed 33.15.
// - High-word bits 31..16 ignored on write, read as zero.
// - Fills use depth x-step as depth x increment, signed 17.15.
// - Strokes use depth x-step as major-axis increment, signed 17.15.
// - x-step write: bits 31..16 to high 15..0, bits 15..0 to low 31..16.
// - x-step write clears bits 15..0 of its wide low word.
// - y-step write maps into wide y-step likewise, clearing low 15..0.
// - Colour registers hold signed 9.15 in bits 23..0.
// - Red accumulator preloaded, steps down left edge for fills.
// - Red accumulator carries current pixel red for strokes.
// - Mapped fill red scans modulation factor or decal colour.
// - Red x-step: x or major axis increment.
// - Red y-step: y or diagonal axis increment.
// - Green accumulator behaves like red, preloaded by software.
// - Green x-step: x or major axis increment.
// - Green y-step: y or diagonal axis increment.
// - Blue accumulator behaves like red, preloaded by software.
// - All registers 32 bits, loaded through the drawing FIFO; only the wide y-step words read back.
// - Blue x-step and y-step registers hold blue increments.
module sdir_regs (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        fifo_valid,
   input  wire logic [13:0] fifo_addr,
   input  wire logic [31:0] fifo_data,
   input  wire logic        step_x,
   input  wire logic        step_y,
   input  wire logic [13:0] rd_addr,
   output logic             fifo_ready,
   output logic [47:0]      depth_acc,
   output logic [47:0]      depth_x_inc,
   output logic [47:0]      depth_y_inc,
   output logic [23:0]      red_acc,
   output logic [23:0]      red_x_inc,
   output logic [23:0]      red_y_inc,
   output logic [23:0]      green_acc,
   output logic [23:0]      green_x_inc,
   output logic [23:0]      green_y_inc,
   output logic [23:0]      blue_acc,
   output logic [23:0]      blue_x_inc,
   output logic [23:0]      blue_y_inc,
   output logic [31:0]      rd_data
);
   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   sdir_load_if ld ();
   logic wr_en;

   // Drawing FIFO pops one entry a cycle; no stall in this bank
   assign wr_en = fifo_valid;

   sdir_decode u_dec (
      .wr_en   (wr_en),
      .wr_addr (fifo_addr),
      .wr_data (fifo_data),
      .ld      (ld)
   );

   // ------------------------------------------------------------------
   // Step selection
   // ------------------------------------------------------------------
   sdir_pkg::sdir_step_t step;
   // Pixel step wins if both arrive, as in the testbench's last step, which asks both at once
   assign step = step_x ? sdir_pkg::SDIR_STEP_X
               : step_y ? sdir_pkg::SDIR_STEP_Y
               : sdir_pkg::SDIR_STEP_NONE;

   // ------------------------------------------------------------------
   // Depth datapath (33.15 fields, 48 bits)
   // ------------------------------------------------------------------
   logic [47:0] dacc_q;
   logic [47:0] dacc_d;
   logic [47:0] dx_q;
   logic [47:0] dx_d;
   logic [47:0] dy_q;
   logic [47:0] dy_d;
   logic [47:0] alias_val;

   // 17.15 alias: no sign extension, fraction lands in low-word 31..16, 15..0 cleared
   function automatic logic [47:0] alias48(input logic [31:0] v);
      alias48 = {v[31:16], v[15:0], 16'h0000};
   endfunction

   assign alias_val = alias48(ld.data);

   logic [47:0] dacc_sum_x;
   logic [47:0] dacc_sum_y;

   // Sums wrap; the carry out of bit 47 is dropped on purpose
   assign dacc_sum_x = 48'(dacc_q + dx_q);
   assign dacc_sum_y = 48'(dacc_q + dy_q);

   // Accumulator 32-bit write is treated like the step aliases
   assign dacc_d = ld.wr_depth_acc ? alias_val
                 : (step == sdir_pkg::SDIR_STEP_X) ? dacc_sum_x
                 : (step == sdir_pkg::SDIR_STEP_Y) ? dacc_sum_y
                 : dacc_q;

   assign dx_d = ld.wr_depth_x ? alias_val : dx_q;

   logic [47:0] dy_hi_word;
   logic [47:0] dy_lo_word;

   // High word keeps only 15..0; bits 31..16 of the write are dropped
   assign dy_hi_word = {ld.data[15:0], dy_q[31:0]};
   assign dy_lo_word = {dy_q[47:32], ld.data};
   assign dy_d = ld.wr_depth_y ? alias_val
               : ld.wr_wide_hi ? dy_hi_word
               : ld.wr_wide_lo ? dy_lo_word
               : dy_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dacc_q <= sdir_pkg::WIDE_RST;
      end else begin
         dacc_q <= dacc_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dx_q <= sdir_pkg::WIDE_RST;
      end else begin
         dx_q <= dx_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dy_q <= sdir_pkg::WIDE_RST;
      end else begin
         dy_q <= dy_d;
      end
   end

   // ------------------------------------------------------------------
   // Colour channels
   // ------------------------------------------------------------------
   logic [23:0] c_acc [3];
   logic [23:0] c_x   [3];
   logic [23:0] c_y   [3];

   // Red channel
   sdir_color_chan #(
      .W (sdir_pkg::COLOR_W)
   ) u_red (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_acc  (ld.wr_acc[0]),
      .wr_x    (ld.wr_x[0]),
      .wr_y    (ld.wr_y[0]),
      .data    (ld.data),
      .step    (step),
      .acc     (c_acc[0]),
      .x_inc   (c_x[0]),
      .y_inc   (c_y[0])
   );

   // Green channel
   sdir_color_chan #(
      .W (sdir_pkg::COLOR_W)
   ) u_green (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_acc  (ld.wr_acc[1]),
      .wr_x    (ld.wr_x[1]),
      .wr_y    (ld.wr_y[1]),
      .data    (ld.data),
      .step    (step),
      .acc     (c_acc[1]),
      .x_inc   (c_x[1]),
      .y_inc   (c_y[1])
   );

   // Blue channel
   sdir_color_chan #(
      .W (sdir_pkg::COLOR_W)
   ) u_blue (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_acc  (ld.wr_acc[2]),
      .wr_x    (ld.wr_x[2]),
      .wr_y    (ld.wr_y[2]),
      .data    (ld.data),
      .step    (step),
      .acc     (c_acc[2]),
      .x_inc   (c_x[2]),
      .y_inc   (c_y[2])
   );

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   logic        rd_hit_hi;
   logic        rd_hit_lo;
   logic [31:0] rd_d;

   assign rd_hit_hi = (rd_addr == sdir_pkg::OFF_WIDE_Y_HIGH);
   assign rd_hit_lo = (rd_addr == sdir_pkg::OFF_WIDE_Y_LOW);

   // Only the wide y-step words read back, high word zero above bit 15; other addresses read zero
   assign rd_d = rd_hit_hi ? {16'h0000, dy_q[47:32]}
               : rd_hit_lo ? dy_q[31:0]
               : sdir_pkg::WORD_RST;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_data <= sdir_pkg::WORD_RST;
      end else begin
         rd_data <= rd_d;
      end
   end

   // ------------------------------------------------------------------
   // Ready flag
   // ------------------------------------------------------------------
   // No stall: the bank takes one write every cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fifo_ready <= 1'b0;
      end else begin
         fifo_ready <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Depth outputs
   // ------------------------------------------------------------------
   // Same next value as the internal copy, so no extra lag here
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         depth_acc <= sdir_pkg::WIDE_RST;
      end else begin
         depth_acc <= dacc_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         depth_x_inc <= sdir_pkg::WIDE_RST;
      end else begin
         depth_x_inc <= dx_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         depth_y_inc <= sdir_pkg::WIDE_RST;
      end else begin
         depth_y_inc <= dy_d;
      end
   end

   // ------------------------------------------------------------------
   // Red outputs
   // ------------------------------------------------------------------
   // Colour ports trail the channel registers by one cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         red_acc <= sdir_pkg::COLOR_RST;
      end else begin
         red_acc <= c_acc[0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         red_x_inc <= sdir_pkg::COLOR_RST;
      end else begin
         red_x_inc <= c_x[0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         red_y_inc <= sdir_pkg::COLOR_RST;
      end else begin
         red_y_inc <= c_y[0];
      end
   end

   // ------------------------------------------------------------------
   // Green outputs
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         green_acc <= sdir_pkg::COLOR_RST;
      end else begin
         green_acc <= c_acc[1];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         green_x_inc <= sdir_pkg::COLOR_RST;
      end else begin
         green_x_inc <= c_x[1];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         green_y_inc <= sdir_pkg::COLOR_RST;
      end else begin
         green_y_inc <= c_y[1];
      end
   end

   // ------------------------------------------------------------------
   // Blue outputs
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blue_acc <= sdir_pkg::COLOR_RST;
      end else begin
         blue_acc <= c_acc[2];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blue_x_inc <= sdir_pkg::COLOR_RST;
      end else begin
         blue_x_inc <= c_x[2];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blue_y_inc <= sdir_pkg::COLOR_RST;
      end else begin
         blue_y_inc <= c_y[2];
      end
   end
endmodule
`default_nettype wire

// *** sdir_regs_checker.sv ***
// Checker: write mapping, alias packing and stepping of the register bank
`timescale 1ns/100ps
`default_nettype none
module sdir_regs_checker (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        fifo_valid,
   input wire logic [13:0] fifo_addr,
   input wire logic [31:0] fifo_data,
   input wire logic        step_x,
   input wire logic        step_y,
   input wire logic [13:0] rd_addr,
   input wire logic [47:0] depth_acc,
   input wire logic [47:0] depth_x_inc,
   input wire logic [47:0] depth_y_inc,
   input wire logic [23:0] red_acc,
   input wire logic [23:0] red_x_inc,
   input wire logic [23:0] green_acc,
   input wire logic [23:0] green_y_inc,
   input wire logic [23:0] blue_x_inc,
   input wire logic [31:0] rd_data
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // Write is taken at one edge, visible on the colour ports two edges on, on the depth ports one
   sequence wr_s(logic [13:0] a);
      fifo_valid && fifo_addr == a;
   endsequence
   wide_low_a: assert property (wr_s(sdir_pkg::OFF_WIDE_Y_LOW) |-> ##2
      depth_y_inc[31:0] == $past(fifo_data, 2)) else $error("wide low word lost");
   wide_high_a: assert property (wr_s(sdir_pkg::OFF_WIDE_Y_HIGH) |-> ##2
      depth_y_inc[47:32] == $past(fifo_data[15:0], 2)) else $error("wide high word lost");
   y_alias_a: assert property (wr_s(sdir_pkg::OFF_DEPTH_Y) |-> ##2
      depth_y_inc == {$past(fifo_data, 2), 16'h0000}) else $error("y alias packing wrong");
   x_alias_a: assert property (wr_s(sdir_pkg::OFF_DEPTH_X) |-> ##2
      depth_x_inc == {$past(fifo_data, 2), 16'h0000}) else $error("x alias packing wrong");
   red_load_a: assert property (wr_s(sdir_pkg::OFF_RED_ACC) |-> ##2
      red_acc == $past(fifo_data[23:0], 2)) else $error("red start not loaded");
   green_y_a: assert property (wr_s(sdir_pkg::OFF_GREEN_Y) |-> ##2
      green_y_inc == $past(fifo_data[23:0], 2)) else $error("green y step not loaded");
   blue_x_a: assert property (wr_s(sdir_pkg::OFF_BLUE_X) |-> ##2
      blue_x_inc == $past(fifo_data[23:0], 2)) else $error("blue x step not loaded");
   red_step_a: assert property (step_x && !fifo_valid |-> ##2
      red_acc == $past(red_acc) + $past(red_x_inc)) else $error("red pixel step wrong");
   // Depth ports carry no output lag, so the sum shows one edge on
   depth_step_a: assert property (step_x && !fifo_valid |-> ##1
      depth_acc == $past(depth_acc) + $past(depth_x_inc)) else $error("depth step wrong");
   green_line_a: assert property (step_y && !step_x && !fifo_valid |-> ##2
      green_acc == $past(green_acc) + $past(green_y_inc)) else $error("green line step wrong");
   high_read_a: assert property (rd_addr == sdir_pkg::OFF_WIDE_Y_HIGH |=>
      rd_data[31:16] == 16'h0000) else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// *** tb_sdir_regs.sv ***
// Testbench: register bank loads, aliases and accumulator steps
`timescale 1ns/100ps
`default_nettype none
module tb_sdir_regs;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        fifo_valid = 1'b0;
   logic [13:0] fifo_addr = 14'h0000;
   logic [31:0] fifo_data = 32'h0000_0000;
   logic        step_x = 1'b0, step_y = 1'b0;
   logic [13:0] rd_addr = 14'h0000;
   logic        fifo_ready;
   logic [47:0] depth_acc, depth_x_inc, depth_y_inc, ed, edx, edy;
   logic [23:0] red_acc, red_x_inc, red_y_inc, green_acc, green_x_inc, green_y_inc;
   logic [23:0] blue_acc, blue_x_inc, blue_y_inc;
   logic [31:0] rd_data;
   logic [23:0] col [9];
   logic [23:0] e [9];
   int          error_cnt = 0;
   int          compares = 0;
   localparam logic [13:0] CA [9] = '{sdir_pkg::OFF_RED_ACC, sdir_pkg::OFF_RED_X,
      sdir_pkg::OFF_RED_Y, sdir_pkg::OFF_GREEN_ACC, sdir_pkg::OFF_GREEN_X,
      sdir_pkg::OFF_GREEN_Y, sdir_pkg::OFF_BLUE_ACC, sdir_pkg::OFF_BLUE_X,
      sdir_pkg::OFF_BLUE_Y};
   always #50 ref_clk = ~ref_clk;
   always_comb col = '{red_acc, red_x_inc, red_y_inc, green_acc, green_x_inc,
      green_y_inc, blue_acc, blue_x_inc, blue_y_inc};
   sdir_regs dut_u (.ref_clk, .rst_n, .fifo_valid, .fifo_addr, .fifo_data, .step_x,
      .step_y, .rd_addr, .fifo_ready, .depth_acc, .depth_x_inc, .depth_y_inc, .red_acc,
      .red_x_inc, .red_y_inc, .green_acc, .green_x_inc, .green_y_inc, .blue_acc,
      .blue_x_inc, .blue_y_inc, .rd_data);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(logic [47:0] got, logic [47:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Valid stays up between writes, so back-to-back calls never glitch it
   task automatic wr(logic [13:0] a, logic [31:0] d);
      fifo_valid <= 1'b1;
      fifo_addr <= a;
      fifo_data <= d;
      @(posedge ref_clk);
   endtask
   task automatic idle();
      fifo_valid <= 1'b0;
      step_x <= 1'b0;
      step_y <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic rd(logic [13:0] a, logic [31:0] exp);
      rd_addr <= a;
      repeat (3) @(posedge ref_clk);
      chk(48'(rd_data), 48'(exp));
   endtask
   task automatic step(logic x, logic y);
      step_x <= x;
      step_y <= y;
      @(posedge ref_clk);
      for (int c = 0; c < 3; c++) e[3*c] = e[3*c] + (x ? e[3*c+1] : e[3*c+2]);
      ed = ed + (x ? edx : edy);
      idle();
      for (int c = 0; c < 3; c++) chk(48'(col[3*c]), 48'(e[3*c]));
      chk(depth_acc, ed);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      wr(sdir_pkg::OFF_WIDE_Y_LOW, 32'h1234_5678);
      wr(sdir_pkg::OFF_WIDE_Y_HIGH, 32'hABCD_9876);
      idle();
      chk(depth_y_inc, 48'h9876_1234_5678);
      rd(sdir_pkg::OFF_WIDE_Y_HIGH, 32'h0000_9876);
      wr(sdir_pkg::OFF_DEPTH_Y, 32'h8001_7FFF);
      wr(14'h1cc4, 32'hFFFF_FFFF);
      idle();
      chk(depth_y_inc, 48'h8001_7FFF_0000);
      rd(sdir_pkg::OFF_WIDE_Y_LOW, 32'h7FFF_0000);
      wr(sdir_pkg::OFF_DEPTH_X, 32'hFFFF_0001);
      wr(sdir_pkg::OFF_DEPTH_ACC, 32'h0000_0003);
      idle();
      chk(depth_x_inc, 48'hFFFF_0001_0000);
      chk(depth_acc, 48'h0000_0003_0000);
      // Software keeps the top byte of colour writes zero
      for (int i = 0; i < 9; i++) begin
         e[i] = 24'h7F_FFF0 + 24'(i);
         wr(CA[i], {8'h00, e[i]});
      end
      idle();
      for (int i = 0; i < 9; i++) chk(48'(col[i]), 48'(e[i]));
      ed = 48'h0000_0003_0000;
      edx = 48'hFFFF_0001_0000;
      edy = 48'h8001_7FFF_0000;
      step(1'b1, 1'b0);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(48'(fifo_ready), 48'h0000_0000_0000);
      chk(48'(red_acc), 48'h0000_0000_0000);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(48'(fifo_ready), 48'h0000_0000_0001);
      end_of_test();
   end
endmodule
bind sdir_regs sdir_regs_checker chk_u (.ref_clk, .rst_n, .fifo_valid, .fifo_addr,
   .fifo_data, .step_x, .step_y, .rd_addr, .depth_acc, .depth_x_inc, .depth_y_inc,
   .red_acc, .red_x_inc, .green_acc, .green_y_inc, .blue_x_inc, .rd_data);
`default_nettype wire
